// ==== logic/pcm_defines.vh ====
`ifndef PCM_DEFINES_VH
`define PCM_DEFINES_VH
// ----------------------------------------
// Register word offsets
// ----------------------------------------
`define PCM_OFF_CONFIG     4'h0
`define PCM_OFF_STATUS     4'h1
`define PCM_OFF_POSITION   4'h2
`define PCM_OFF_INERTIA    4'h3
`define PCM_OFF_IRQ_STAT   4'h4
`define PCM_OFF_IRQ_EN     4'h5
`define PCM_OFF_IRQ_CLR    4'h6
`define PCM_OFF_PARAM      4'h7
// ----------------------------------------
// Function switch bit positions
// ----------------------------------------
`define PCM_SW_TUNE        0
`define PCM_SW_BRAKE       1
`define PCM_SW_PULSE_MODE  2
`define PCM_SW_RES_LO      3
`define PCM_SW_RES_HI      4
`define PCM_SW_SOURCE      5
// ----------------------------------------
// Resolution codes and pulses per rotation
// ----------------------------------------
`define PCM_RES_1000       2'h0
`define PCM_RES_10000      2'h1
`define PCM_RES_500        2'h2
`define PCM_RES_5000       2'h3
`define PCM_PPR_1000       14'h03E8
`define PCM_PPR_10000      14'h2710
`define PCM_PPR_500        14'h01F4
`define PCM_PPR_5000       14'h1388
// ----------------------------------------
// Interrupt bit positions
// ----------------------------------------
`define PCM_IRQ_REV        0
`define PCM_IRQ_ALARM      1
`define PCM_IRQ_TUNE_DONE  2
`define PCM_IRQ_READY      3
// ----------------------------------------
// Reset values and timing
// ----------------------------------------
`define PCM_PARAM_RESET    6'h00
`define PCM_INERTIA_RESET  16'h0064
`define PCM_CLK_HZ         25000000
`define PCM_ALARM_DELAY_MS 2000
`define PCM_ALARM_DELAY_CYC (`PCM_CLK_HZ / 1000 * `PCM_ALARM_DELAY_MS)
`endif

// ==== logic/pcm_pulse_config.v ====
// Operation
// [RQ1] Switch 6 selects switches or stored parameters
// [RQ2] Switches 5,4 decode 10000, 500, 5000 resolution
// [RQ3] Default resolution: 1000 pulses per revolution
// [RQ4] Switch 3 off: separate forward/reverse pulses
// [RQ5] Switch 3 on: feed pulse plus direction
// [RQ6] Host pulses match selected input mode
// [RQ7] Brake on: dynamic brake on run off/alarm
// [RQ8] Brake off: coast on run off/alarm
// [RQ9] Power loss always applies dynamic brake
// [RQ10] Switch 1 on runs online autotuning
// [RQ11] Switch 1 off stores inertia ratio result
// [RQ12] Alarm output invalid about 2 s after power-up
// [RQ13] Host ignores alarm until it turns on
// [RQ14] Host keeps run off during power-up
// [RQ15] Switches 2-6 sampled only at power-up
// [RQ16] Run turns servo on, clears servo-off
// [RQ17] Signed position count: forward up, reverse down
// [RQ18] Direction sampled at each feed pulse edge
`timescale 1ns/1ns
`include "pcm_defines.vh"

module pcm_pulse_config #(
  parameter ALARM_DELAY_CYC = `PCM_ALARM_DELAY_CYC
) (
  // Clock and reset
  input  wire        clk,
  input  wire        rst,
  // Avalon-MM slave
  input  wire [3:0]  avs_address,
  input  wire        avs_read,
  input  wire        avs_write,
  input  wire [31:0] avs_writedata,
  output reg  [31:0] avs_readdata,
  output reg         avs_waitrequest,
  // Function switches and power
  input  wire [5:0]  function_switch,
  input  wire        power_lost,
  // Command pulse pins
  input  wire        forward_step_pulse,
  input  wire        reverse_step_pulse,
  input  wire        feed_step_pulse,
  input  wire        direction_level,
  input  wire        run_command,
  input  wire        fault_detect,
  // Drive outputs
  output reg         servo_on,
  output reg         servo_off_ind,
  output reg         dynamic_brake,
  output reg         coast_stop,
  output reg         alarm_output,
  output reg         autotune_active,
  output reg  [13:0] pulses_per_rev,
  output reg         irq
);

  // ----------------------------------------
  // Input synchronisers
  // ----------------------------------------
  reg [12:0] sync1_reg;
  reg [12:0] sync2_reg;
  wire [12:0] pins = {function_switch, power_lost, forward_step_pulse, reverse_step_pulse,
                      feed_step_pulse, direction_level, run_command, fault_detect};
  // Two flops per pin
  always @(posedge clk)
  begin
    sync1_reg <= pins;
    sync2_reg <= sync1_reg;
  end
  wire [5:0] sw_s   = sync2_reg[12:7];
  wire       pwr_s  = sync2_reg[6];
  wire       fwd_s  = sync2_reg[5];
  wire       rev_s  = sync2_reg[4];
  wire       feed_s = sync2_reg[3];
  wire       dir_s  = sync2_reg[2];
  wire       run_s  = sync2_reg[1];
  wire       flt_s  = sync2_reg[0];

  // ----------------------------------------
  // Power-up latch and alarm delay
  // ----------------------------------------
  reg [26:0] delay_reg;
  reg        ready_reg;
  reg        latched_reg;
  reg [5:0]  sw_lat_reg;
  reg [5:0]  param_reg;
  // Switches 2-6 caught once after reset; switch 1 stays live
  always @(posedge clk)
  begin
    if (rst)
    begin
      delay_reg   <= 27'h0000000;
      ready_reg   <= 1'b0;
      latched_reg <= 1'b0;
      sw_lat_reg  <= 6'h00;
    end
    else
    begin
      if (!latched_reg)
      begin
        sw_lat_reg  <= sw_s;                      // RQ15
        latched_reg <= 1'b1;
      end
      if (!ready_reg)
      begin
        if (delay_reg == ALARM_DELAY_CYC - 1)
          ready_reg <= 1'b1;                      // RQ12
        else
          delay_reg <= delay_reg + 27'h0000001;
      end
    end
  end

  // Effective setting: switches or stored parameter
  wire [5:0] eff = sw_lat_reg[`PCM_SW_SOURCE] ? param_reg : sw_lat_reg;   // RQ1
  wire       mode_dir  = eff[`PCM_SW_PULSE_MODE];
  wire       brake_en  = eff[`PCM_SW_BRAKE];
  wire [1:0] res_code  = {eff[`PCM_SW_RES_HI], eff[`PCM_SW_RES_LO]};
  wire       tune_live = sw_lat_reg[`PCM_SW_SOURCE] ? param_reg[`PCM_SW_TUNE] : sw_s[`PCM_SW_TUNE];

  // ----------------------------------------
  // Pulse decoding and position count
  // ----------------------------------------
  reg        fwd_d_reg;
  reg        rev_d_reg;
  reg        feed_d_reg;
  reg [31:0] pos_reg;
  reg [13:0] step_cnt_reg;
  reg        rev_evt_reg;
  wire fwd_edge  = fwd_s & ~fwd_d_reg;
  wire rev_edge  = rev_s & ~rev_d_reg;
  wire feed_edge = feed_s & ~feed_d_reg;
  reg  step_up;
  reg  step_dn;
  // Mode-dependent step decode
  always @*
  begin
    step_up = 1'b0;
    step_dn = 1'b0;
    if (mode_dir)
    begin
      step_up = feed_edge & dir_s;                // RQ5 RQ18
      step_dn = feed_edge & ~dir_s;               // RQ18
    end
    else
    begin
      step_up = fwd_edge & ~rev_edge;             // RQ4
      step_dn = rev_edge & ~fwd_edge;             // RQ4
    end
  end
  reg [13:0] pulses_per_rev_next;
  // Resolution lookup
  always @*
  begin
    case (res_code)
      `PCM_RES_10000: pulses_per_rev_next = `PCM_PPR_10000;   // RQ2
      `PCM_RES_500:   pulses_per_rev_next = `PCM_PPR_500;     // RQ2
      `PCM_RES_5000:  pulses_per_rev_next = `PCM_PPR_5000;    // RQ2
      default:        pulses_per_rev_next = `PCM_PPR_1000;    // RQ3
    endcase
  end
  // Position and per-revolution step counter
  always @(posedge clk)
  begin
    fwd_d_reg  <= fwd_s;
    rev_d_reg  <= rev_s;
    feed_d_reg <= feed_s;
    if (rst)
    begin
      pos_reg        <= 32'h00000000;
      step_cnt_reg   <= 14'h0000;
      rev_evt_reg    <= 1'b0;
      pulses_per_rev <= `PCM_PPR_1000;
    end
    else
    begin
      pulses_per_rev <= pulses_per_rev_next;
      rev_evt_reg    <= 1'b0;
      if (servo_on && (step_up || step_dn))
      begin
        pos_reg <= step_up ? pos_reg + 32'h00000001 : pos_reg - 32'h00000001;   // RQ17
        if (step_cnt_reg == pulses_per_rev - 14'h0001)
        begin
          step_cnt_reg <= 14'h0000;               // RQ3
          rev_evt_reg  <= 1'b1;
        end
        else
          step_cnt_reg <= step_cnt_reg + 14'h0001;
      end
    end
  end

  // ----------------------------------------
  // Servo, brake, alarm and autotuning
  // ----------------------------------------
  reg        tune_d_reg;
  reg [15:0] inertia_reg;
  reg [15:0] tune_acc_reg;
  reg        tune_done_evt;
  reg        alarm_evt;
  always @(posedge clk)
  begin
    if (rst)
    begin
      servo_on        <= 1'b0;
      servo_off_ind   <= 1'b1;
      dynamic_brake   <= 1'b1;
      coast_stop      <= 1'b0;
      alarm_output    <= 1'b0;
      autotune_active <= 1'b0;
      tune_d_reg      <= 1'b0;
      inertia_reg     <= `PCM_INERTIA_RESET;
      tune_acc_reg    <= `PCM_INERTIA_RESET;
      tune_done_evt   <= 1'b0;
      alarm_evt       <= 1'b0;
    end
    else
    begin
      alarm_output  <= ready_reg & ~flt_s;        // RQ12
      alarm_evt     <= ready_reg & flt_s & alarm_output;
      servo_on      <= ready_reg & run_s & ~flt_s & ~pwr_s;   // RQ16
      servo_off_ind <= ~(ready_reg & run_s & ~flt_s & ~pwr_s); // RQ16
      if (pwr_s)
      begin
        dynamic_brake <= 1'b1;                    // RQ9
        coast_stop    <= 1'b0;
      end
      else if (!run_s || flt_s || !ready_reg)
      begin
        dynamic_brake <= brake_en;                // RQ7
        coast_stop    <= ~brake_en;               // RQ8
      end
      else
      begin
        dynamic_brake <= 1'b0;
        coast_stop    <= 1'b0;
      end
      // Tuning flag follows switch 1, or param bit 0 when switch 6 selects parameters; steps are counted only while servo is on
      tune_d_reg      <= tune_live;
      autotune_active <= tune_live;               // RQ10
      tune_done_evt   <= 1'b0;
      if (tune_live && servo_on && (step_up || step_dn))
        tune_acc_reg <= tune_acc_reg + 16'h0001;  // RQ10
      if (tune_d_reg && !tune_live)
      begin
        inertia_reg   <= tune_acc_reg;            // RQ11
        tune_done_evt <= 1'b1;
      end
    end
  end

  // ----------------------------------------
  // Interrupt status
  // ----------------------------------------
  reg  [3:0] irq_stat_reg;
  reg  [3:0] irq_en_reg;
  reg        delay_done_d_reg;
  // Event pulses; bit 3 marks the end of the alarm delay
  wire [3:0] irq_set = {ready_reg & ~delay_done_d_reg, tune_done_evt, alarm_evt, rev_evt_reg};
  wire       wr_acc = avs_write & ~avs_waitrequest;
  wire       rd_acc = avs_read & ~avs_waitrequest;
  // Sticky bits: set wins over clear
  always @(posedge clk)
  begin
    if (rst)
    begin
      irq_stat_reg     <= 4'h0;
      delay_done_d_reg <= 1'b0;
      irq              <= 1'b0;
    end
    else
    begin
      delay_done_d_reg <= ready_reg;
      if (wr_acc && avs_address == `PCM_OFF_IRQ_CLR)
        irq_stat_reg <= (irq_stat_reg & ~avs_writedata[3:0]) | irq_set;
      else
        irq_stat_reg <= irq_stat_reg | irq_set;
      irq <= |(irq_stat_reg & irq_en_reg);
    end
  end

  // ----------------------------------------
  // Avalon-MM register access
  // ----------------------------------------
  // One wait cycle, then answer
  always @(posedge clk)
  begin
    if (rst)
    begin
      avs_waitrequest <= 1'b1;
      avs_readdata    <= 32'h00000000;
      irq_en_reg      <= 4'h0;
      param_reg       <= `PCM_PARAM_RESET;
    end
    else
    begin
      avs_waitrequest <= ~((avs_read | avs_write) & avs_waitrequest);
      if (wr_acc)
      begin
        case (avs_address)
          `PCM_OFF_IRQ_EN: irq_en_reg <= avs_writedata[3:0];
          `PCM_OFF_PARAM:  param_reg  <= avs_writedata[5:0];
          default:         irq_en_reg <= irq_en_reg;
        endcase
      end
      if ((avs_read | avs_write) & avs_waitrequest)
      begin
        case (avs_address)
          `PCM_OFF_CONFIG:   avs_readdata <= {26'h0000000, eff};
          `PCM_OFF_STATUS:   avs_readdata <= {22'h000000, pulses_per_rev[13:10] & 4'h0, servo_on, servo_off_ind,
                                              dynamic_brake, coast_stop, alarm_output, autotune_active};
          `PCM_OFF_POSITION: avs_readdata <= pos_reg;
          `PCM_OFF_INERTIA:  avs_readdata <= {16'h0000, inertia_reg};
          `PCM_OFF_IRQ_STAT: avs_readdata <= {28'h0000000, irq_stat_reg};
          `PCM_OFF_IRQ_EN:   avs_readdata <= {28'h0000000, irq_en_reg};
          `PCM_OFF_PARAM:    avs_readdata <= {26'h0000000, param_reg};
          default:           avs_readdata <= 32'h00000000;
        endcase
      end
    end
  end

endmodule // pcm_pulse_config

// ==== verification/pcm_checker.sv ====
`timescale 1ns/1ns
`include "pcm_defines.vh"
module pcm_checker #(
  parameter ALARM_DELAY_CYC = 20
) (
  // Clock, reset and bus handshake
  input wire        clk,
  input wire        rst,
  input wire        avs_read,
  input wire        avs_write,
  input wire        avs_waitrequest,
  // Drive pins
  input wire        power_lost,
  input wire        run_command,
  input wire        servo_on,
  input wire        servo_off_ind,
  input wire        dynamic_brake,
  input wire        coast_stop,
  input wire        alarm_output,
  input wire [13:0] pulses_per_rev
);
  reg [31:0] up_reg;
  // Cycles since reset release, saturating
  always @(posedge clk)
    if (rst)
      up_reg <= 32'h0;
    else if (up_reg < 32'hFFFF)
      up_reg <= up_reg + 32'h1;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  wait_pulse_a: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("ack held too long");
  wait_answer_a: assert property ((avs_read || avs_write) && avs_waitrequest |-> ##[1:2] !avs_waitrequest)
    else $error("bus not answered");
  brake_power_a: assert property (power_lost |-> ##[1:4] dynamic_brake)
    else $error("no brake on power loss");
  servo_clear_a: assert property (servo_on |-> !servo_off_ind)
    else $error("servo off still shown");
  servo_run_a: assert property ($rose(servo_on) |-> $past(run_command))
    else $error("servo on without run");
  res_legal_a: assert property (pulses_per_rev == `PCM_PPR_1000 || pulses_per_rev == `PCM_PPR_10000
    || pulses_per_rev == `PCM_PPR_500 || pulses_per_rev == `PCM_PPR_5000)
    else $error("bad resolution");
  alarm_delay_a: assert property (alarm_output |-> up_reg >= ALARM_DELAY_CYC)
    else $error("alarm valid too early");
  idle_stop_a: assert property (!run_command [*4] |=> dynamic_brake || coast_stop)
    else $error("no stop with run off");
  // Main scenarios reached
  cover property (servo_on);
  cover property (power_lost && dynamic_brake);
  cover property ($rose(alarm_output));
endmodule // pcm_checker

// ==== verification/pcm_host_model.sv ====
`timescale 1ns/1ns
module pcm_host_model (
  // Clock and selected input mode
  input wire clk,
  input wire pulse_dir,
  // Command pins
  output reg forward_step_pulse = 1'b0,
  output reg reverse_step_pulse = 1'b0,
  output reg feed_step_pulse    = 1'b0,
  output reg direction_level    = 1'b0,
  output reg run_command        = 1'b0
);
  // Run request, off until the bench asks
  task automatic set_run(input logic on);
    @(posedge clk);
    run_command <= on;
  endtask
  // One step in the format of the device mode
  task automatic step(input logic fwd);
    @(posedge clk);
    direction_level <= fwd;
    @(posedge clk);
    forward_step_pulse <= !pulse_dir && fwd;
    reverse_step_pulse <= !pulse_dir && !fwd;
    feed_step_pulse <= pulse_dir;
    repeat (3) @(posedge clk);
    forward_step_pulse <= 1'b0;
    reverse_step_pulse <= 1'b0;
    feed_step_pulse <= 1'b0;
    direction_level <= !fwd;
    repeat (3) @(posedge clk);
  endtask
endmodule // pcm_host_model

// ==== verification/testbench.sv ====
`timescale 1ns/1ns
`include "pcm_defines.vh"
module testbench;
  localparam DLY = 20;
  reg          clk = 0, rst = 1, avs_read = 0, avs_write = 0;
  reg          power_lost = 0, fault_detect = 0;
  reg  [3:0]   avs_address = 0;
  reg  [31:0]  avs_writedata = 0;
  reg  [5:0]   function_switch = 0, sw = 0;
  wire [31:0]  avs_readdata;
  wire [13:0]  pulses_per_rev;
  wire         avs_waitrequest, servo_on, servo_off_ind, dynamic_brake, coast_stop;
  wire         alarm_output, autotune_active, irq, fwd_p, rev_p, feed_p, dir_l, run_c;
  int          errors = 0, cmp_count = 0, cyc = 0, i, k, nf, nr;
  logic [31:0] exp_q[$], msk_q[$];
  logic [13:0] ppr_tab [4] = '{`PCM_PPR_1000, `PCM_PPR_10000, `PCM_PPR_500, `PCM_PPR_5000};
  pcm_pulse_config #(.ALARM_DELAY_CYC(DLY)) pcm_pulse_config_inst (.clk(clk), .rst(rst),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .function_switch(function_switch),
    .power_lost(power_lost), .forward_step_pulse(fwd_p), .reverse_step_pulse(rev_p), .feed_step_pulse(feed_p),
    .direction_level(dir_l), .run_command(run_c), .fault_detect(fault_detect), .servo_on(servo_on),
    .servo_off_ind(servo_off_ind), .dynamic_brake(dynamic_brake), .coast_stop(coast_stop),
    .alarm_output(alarm_output), .autotune_active(autotune_active), .pulses_per_rev(pulses_per_rev), .irq(irq));
  pcm_host_model pcm_host_model_inst (.clk(clk), .pulse_dir(sw[2]), .forward_step_pulse(fwd_p),
    .reverse_step_pulse(rev_p), .feed_step_pulse(feed_p), .direction_level(dir_l), .run_command(run_c));
  // Clock and hang guard
  initial
    forever #20 clk = ~clk;
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 40000)
    begin
      errors++;
      tally_and_finish();
    end
  end
  task automatic tally_and_finish;
    $display("compares %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic cmp(input logic [31:0] got, input logic [31:0] e, input logic [31:0] m);
    cmp_count++;
    if ((got & m) !== (e & m))
    begin
      errors++;
      $display("[ERR] %0t got %h want %h", $time, got & m, e & m);
    end
  endtask
  // One bus access, held until the ack edge
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_read <= !wr;
    avs_write <= wr;
    do @(posedge clk); while (avs_waitrequest !== 1'b0);
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] e, input logic [31:0] m);
    exp_q.push_back(e);
    msk_q.push_back(m);
    bus(1'b0, a, 32'h0);
  endtask
  // Read answers paired with the oldest note
  always @(posedge clk)
    if (avs_read === 1'b1 && avs_waitrequest === 1'b0 && exp_q.size() > 0)
      cmp(avs_readdata, exp_q.pop_front(), msk_q.pop_front());
  // Port compare three edges on, once the registered result stands
  task automatic chk_port(input logic sel_irq, input logic [31:0] e);
    repeat (3) @(posedge clk);
    cmp(sel_irq ? {31'h0, irq} : {18'h0, pulses_per_rev}, e, 32'h3FFF);
  endtask
  task automatic powerup(input logic [5:0] s, input logic ready);
    pcm_host_model_inst.set_run(1'b0);
    rst <= 1'b1;
    sw <= s;
    function_switch <= s;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    if (ready)
      repeat (DLY + 10) @(posedge clk);
  endtask
  // Main sequence
  initial
  begin
    k = $urandom(32'h54cadec7);
    for (i = 0; i < 4; i++)
    begin
      powerup({1'b0, i[1:0], i[0], i[1] ^ i[0], 1'b0}, 1'b0);
      rd(`PCM_OFF_STATUS, 32'h0, 32'h02);
      rd(`PCM_OFF_CONFIG, sw, 32'h3F);
      chk_port(1'b0, {18'h0, ppr_tab[i]});
      function_switch <= sw ^ 6'($urandom & 32'h3E);
      repeat (DLY + 10) @(posedge clk);
      rd(`PCM_OFF_CONFIG, sw, 32'h3E);
      rd(`PCM_OFF_STATUS, {26'h0, 2'b01, sw[1], ~sw[1], 2'b10}, 32'h3F);
      chk_port(1'b0, {18'h0, ppr_tab[i]});
      pcm_host_model_inst.set_run(1'b1);
      repeat (8) @(posedge clk);
      rd(`PCM_OFF_STATUS, 32'h22, 32'h3F);
      nf = $urandom_range(6, 1);
      nr = $urandom_range(5, 0);
      for (k = 0; k < nf + nr; k++)
        pcm_host_model_inst.step(k < nf);
      rd(`PCM_OFF_POSITION, nf - nr, 32'hFFFF);
      power_lost <= 1'b1;
      repeat (4) @(posedge clk);
      rd(`PCM_OFF_STATUS, 32'h08, 32'h08);
      power_lost <= 1'b0;
      $display("test %0d done", i);
    end
    powerup(6'h02, 1'b1);
    rd(`PCM_OFF_IRQ_STAT, 32'h08, 32'h08);
    pcm_host_model_inst.set_run(1'b1);
    repeat (8) @(posedge clk);
    fault_detect <= 1'b1;
    repeat (4) @(posedge clk);
    rd(`PCM_OFF_STATUS, 32'h08, 32'h2A);
    fault_detect <= 1'b0;
    rd(`PCM_OFF_IRQ_STAT, 32'h02, 32'h02);
    bus(1'b1, `PCM_OFF_IRQ_EN, 32'h02);
    chk_port(1'b1, 32'h1);
    bus(1'b1, `PCM_OFF_IRQ_EN, 32'h00);
    chk_port(1'b1, 32'h0);
    bus(1'b1, `PCM_OFF_IRQ_EN, 32'h02);
    bus(1'b1, `PCM_OFF_IRQ_CLR, 32'h02);
    chk_port(1'b1, 32'h0);
    rd(`PCM_OFF_IRQ_STAT, 32'h0, 32'h02);
    $display("test irq done");
    powerup(6'h20, 1'b0);
    rd(`PCM_OFF_PARAM, `PCM_PARAM_RESET, 32'h3F);
    bus(1'b1, `PCM_OFF_PARAM, 32'h18);
    bus(1'b1, 4'h9, 32'hFF);
    bus(1'b1, `PCM_OFF_POSITION, 32'h55);
    rd(4'h9, 32'h0, 32'hFFFFFFFF);
    rd(`PCM_OFF_POSITION, 32'h0, 32'hFFFF);
    chk_port(1'b0, {18'h0, `PCM_PPR_5000});
    $display("test param done");
    powerup(6'h01, 1'b1);
    rd(`PCM_OFF_INERTIA, `PCM_INERTIA_RESET, 32'hFFFF);
    pcm_host_model_inst.set_run(1'b1);
    repeat (8) @(posedge clk);
    for (k = 0; k < 3; k++)
      pcm_host_model_inst.step(1'b1);
    rd(`PCM_OFF_STATUS, 32'h01, 32'h01);
    function_switch <= 6'h00;
    repeat (10) @(posedge clk);
    rd(`PCM_OFF_INERTIA, `PCM_INERTIA_RESET + 32'h3, 32'hFFFF);
    rd(`PCM_OFF_IRQ_STAT, 32'h04, 32'h04);
    $display("test tune done");
    tally_and_finish();
  end
endmodule // testbench
bind pcm_pulse_config pcm_checker #(.ALARM_DELAY_CYC(ALARM_DELAY_CYC)) chk_inst (.clk(clk), .rst(rst),
  .avs_read(avs_read), .avs_write(avs_write), .avs_waitrequest(avs_waitrequest), .power_lost(power_lost),
  .run_command(run_command), .servo_on(servo_on), .servo_off_ind(servo_off_ind),
  .dynamic_brake(dynamic_brake), .coast_stop(coast_stop), .alarm_output(alarm_output),
  .pulses_per_rev(pulses_per_rev));
